// file: hw/external_interrupt_conditioner.sv
// External interrupt conditioner: six pin filters, trigger detection and control registers
//
// Operation
// - Read-only level bit holds filtered level at request
// - Level bit refreshed on every new request
// - Source four triggers on rise, fall, both, high
// - Trigger codes: rise, fall, both, high level
// - Low-speed modes sample at slow clock over four
// - Fast modes, sources one-four: divider 1/4/8/16, three equal samples
// - Low-speed modes: two equal samples accept level
// - Control register bits seven to five read zero
// - Sources one to four have selectable trigger, filter
// - Sources zero and five: falling edge, fixed filter
// - Fast modes, sources zero/five: two-cycle acceptance
// - Fast modes, sources one-four: three-sample acceptance
// - Low-speed modes: every source uses slow filter
// - Clock gate low stops sampling, edge detection and requests; registers stay accessible
// - Reset clears the clock gate bit
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "extint_regs.svh"
module external_interrupt_conditioner
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`EXTINT_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire extint_pkg::op_mode_t op_mode,
    input wire logic low_freq_clock,
    input wire logic ext_source_zero,
    input wire logic ext_pin1,
    input wire logic ext_pin2,
    input wire logic ext_pin3,
    input wire logic ext_pin4,
    input wire logic ext_source_five,
    input wire logic master_irq_enable,
    input wire logic source0_enable_flag,
    input wire logic source1_enable_flag,
    input wire logic source2_enable_flag,
    input wire logic source3_enable_flag,
    input wire logic source4_enable_flag,
    input wire logic source5_enable_flag,
    output logic [5:0] irq_request
);
    import extint_pkg::*;

    logic extint_clock_gate_ff;
    logic [3:0] ctl_ff [1:4];
    logic [4:1] lvl_ff;
    logic [3:0] gdiv_ff;
    logic [1:0] lfdiv_ff;
    logic [5:0] prev_ff;
    logic [5:0] irq_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [5:0] pins;
    logic [5:0] src_en;
    logic [5:0] filt;
    logic [5:0] tick;
    logic [5:0] raw_req;
    logic high_speed;
    logic run;
    logic lf_tick4;

    assign pins = {ext_source_five, ext_pin4, ext_pin3, ext_pin2, ext_pin1, ext_source_zero};
    assign src_en = {source5_enable_flag, source4_enable_flag, source3_enable_flag,
                     source2_enable_flag, source1_enable_flag, source0_enable_flag};

    // Mode decode; halted modes stop sampling entirely
    assign high_speed = (op_mode == high_speed_run) || (op_mode == high_speed_idle);
    assign run = extint_clock_gate_ff && (op_mode != halted_mode);
    assign lf_tick4 = low_freq_clock && (lfdiv_ff == `EXTINT_LF_DIV_LAST);

    // Gear clock divider for the selectable sample intervals
    always_ff @(posedge clk)
    begin
        if (reset)
            gdiv_ff <= 4'h0;
        else if (run && high_speed)
            gdiv_ff <= gdiv_ff + 4'h1;
    end

    // Slow clock arrives as an enable pulse; divide it by four
    always_ff @(posedge clk)
    begin
        if (reset)
            lfdiv_ff <= 2'h0;
        else if (run && !high_speed && low_freq_clock)
            lfdiv_ff <= lfdiv_ff + 2'h1;
    end

    // Gate bit: reset leaves external interrupts unavailable
    always_ff @(posedge clk)
    begin
        if (reset)
            extint_clock_gate_ff <= 1'b0;
        else if (reg_wr && reg_addr == `EXTINT_ADDR_GATE)
            extint_clock_gate_ff <= reg_wdata[`EXTINT_GATE_BIT];
    end

    genvar i;
    generate
        for (i = 0; i < 6; i++)
        begin : g_src
            logic rise;
            logic fall;
            logic nc_tick;
            trig_t es;

            if (i == 0 || i == 5)
            begin : g_fixed
                // Fixed sources sample every gear clock, falling edge only
                assign es = trig_fall;
                assign nc_tick = 1'b1;
            end
            else
            begin : g_sel
                // Selectable sample interval from the control register
                assign es = trig_t'(ctl_ff[i][`EXTINT_ES_LSB +: 2]);
                always_comb
                begin
                    unique case (ctl_ff[i][`EXTINT_NC_LSB +: 2])
                        2'h0: nc_tick = 1'b1;
                        2'h1: nc_tick = gdiv_ff[1:0] == `EXTINT_DIV4_LAST;
                        2'h2: nc_tick = gdiv_ff[2:0] == `EXTINT_DIV8_LAST;
                        2'h3: nc_tick = gdiv_ff == `EXTINT_DIV16_LAST;
                    endcase
                end

                // Control register write and captured level
                always_ff @(posedge clk)
                begin
                    if (reset)
                        ctl_ff[i] <= `EXTINT_CTL_RESET;
                    else if (reg_wr && reg_addr == `EXTINT_ADDR_CTL1 + 12'(i - 1))
                        ctl_ff[i] <= reg_wdata[3:0];
                end

                always_ff @(posedge clk)
                begin
                    if (reset)
                        lvl_ff[i] <= 1'b0;
                    else if (raw_req[i])
                        lvl_ff[i] <= filt[i];
                end
            end

            // Slow modes override the selected interval
            assign tick[i] = high_speed ? nc_tick : lf_tick4;

            noise_filter u_filter
            (
                .clk(clk),
                .reset(reset),
                .run(run),
                .pin(pins[i]),
                .tick(tick[i]),
                .need_three(high_speed && i != 0 && i != 5),
                .level_ff(filt[i])
            );

            // Trigger detection; high level only exists on source four
            assign rise = filt[i] && !prev_ff[i];
            assign fall = !filt[i] && prev_ff[i];
            always_comb
            begin
                unique case (es)
                    trig_rise: raw_req[i] = run && rise;
                    trig_fall: raw_req[i] = run && fall;
                    trig_both: raw_req[i] = run && (rise || fall);
                    trig_high: raw_req[i] = run && (i == 4) && filt[i];
                endcase
            end
        end
    endgenerate

    // Edge history only advances while the logic is clocked
    always_ff @(posedge clk)
    begin
        if (reset)
            prev_ff <= 6'h00;
        else if (run)
            prev_ff <= filt;
    end

    // Forward requests through the enables
    always_ff @(posedge clk)
    begin
        if (reset)
            irq_ff <= 6'h00;
        else
            irq_ff <= raw_req & src_en & {6{master_irq_enable}};
    end
    assign irq_request = irq_ff;

    // Read decode; unmapped addresses read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        unique case (reg_addr)
            `EXTINT_ADDR_CTL1: nxt_rdata = {3'h0, lvl_ff[1], ctl_ff[1]};
            `EXTINT_ADDR_CTL2: nxt_rdata = {3'h0, lvl_ff[2], ctl_ff[2]};
            `EXTINT_ADDR_CTL3: nxt_rdata = {3'h0, lvl_ff[3], ctl_ff[3]};
            `EXTINT_ADDR_CTL4: nxt_rdata = {3'h0, lvl_ff[4], ctl_ff[4]};
            `EXTINT_ADDR_GATE: nxt_rdata = {7'h00, extint_clock_gate_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_ff <= 8'h00;
        else if (reg_rd)
            rdata_ff <= nxt_rdata;
        else
            rdata_ff <= 8'h00;
    end
    assign reg_rdata = rdata_ff;

    sequence s_read_ctl4;
        reg_rd && reg_addr == `EXTINT_ADDR_CTL4;
    endsequence

    property p_reserved_zero;
        @(posedge clk) disable iff (reset)
        s_read_ctl4 |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4] == $past(lvl_ff[4]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("control register upper bits not zero");

    property p_level_capture;
        @(posedge clk) disable iff (reset)
        raw_req[4] |=> lvl_ff[4] == $past(filt[4]);
    endproperty
    a_level_capture: assert property (p_level_capture)
        else $error("pass level not captured on request");

    property p_gate_after_reset;
        @(posedge clk) disable iff (reset)
        $fell(reset) |-> !extint_clock_gate_ff && irq_request == 6'h00;
    endproperty
    a_gate_after_reset: assert property (p_gate_after_reset)
        else $error("clock gate not cleared by reset");

    property p_gate_blocks;
        @(posedge clk) disable iff (reset)
        !extint_clock_gate_ff |=> irq_request == 6'h00;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks)
        else $error("request while clock gate off");

    property p_enable_needed;
        @(posedge clk) disable iff (reset)
        irq_request[4] |-> $past(master_irq_enable && source4_enable_flag);
    endproperty
    a_enable_needed: assert property (p_enable_needed)
        else $error("request forwarded while disabled");

    property p_fixed_fall;
        @(posedge clk) disable iff (reset)
        irq_request[0] |-> $past(prev_ff[0] && !filt[0]);
    endproperty
    a_fixed_fall: assert property (p_fixed_fall)
        else $error("source zero request not on falling edge");

    property p_rise_only;
        @(posedge clk) disable iff (reset)
        raw_req[4] && ctl_ff[4][3:2] == 2'h0 |-> filt[4] && !prev_ff[4];
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("rising trigger fired without a rising edge");

    sequence s_div4_tick;
        run && high_speed && ctl_ff[4][1:0] == 2'h1 && tick[4];
    endsequence

    property p_div4_spacing;
        @(posedge clk) disable iff (reset)
        s_div4_tick ##1 (run && high_speed && ctl_ff[4][1:0] == 2'h1) [*3]
            |-> !tick[4] && !$past(tick[4]) && !$past(tick[4], 2);
    endproperty
    a_div4_spacing: assert property (p_div4_spacing)
        else $error("divide-by-four sampling too fast");

    property p_slow_tick;
        @(posedge clk) disable iff (reset)
        run && !high_speed && tick[4] |=> (high_speed || !run || !tick[4]) [*3];
    endproperty
    a_slow_tick: assert property (p_slow_tick)
        else $error("slow mode sample not at quarter slow clock");
endmodule

// file: hw/extint_pkg.sv
// Types shared by the external interrupt conditioner
package extint_pkg;
    typedef enum logic [2:0] {
        high_speed_run,
        high_speed_idle,
        low_speed_run,
        low_speed_sleep,
        halted_mode
    } op_mode_t;

    typedef enum logic [1:0] {
        trig_rise,
        trig_fall,
        trig_both,
        trig_high
    } trig_t;
endpackage

// file: hw/extint_regs.svh
// Register map, field positions and timing counts of the external interrupt conditioner
`ifndef EXTINT_REGS_SVH
`define EXTINT_REGS_SVH

`define EXTINT_ADDR_W 12
`define EXTINT_ADDR_CTL1 12'hfd8
`define EXTINT_ADDR_CTL2 12'hfd9
`define EXTINT_ADDR_CTL3 12'hfda
`define EXTINT_ADDR_CTL4 12'hfdb
`define EXTINT_ADDR_GATE 12'hfd6
`define EXTINT_NC_LSB 0
`define EXTINT_ES_LSB 2
`define EXTINT_LVL_BIT 4
`define EXTINT_GATE_BIT 0
`define EXTINT_CTL_RESET 4'h0
`define EXTINT_LF_DIV_LAST 2'h3
`define EXTINT_DIV4_LAST 2'h3
`define EXTINT_DIV8_LAST 3'h7
`define EXTINT_DIV16_LAST 4'hf
`define EXTINT_NEED_TWO 2'h1
`define EXTINT_NEED_THREE 2'h2
`define EXTINT_CNT_MAX 2'h3

`endif

// file: hw/noise_filter.sv
// Sampling noise canceller for one interrupt pin
`timescale 1ns/1ns
`include "extint_regs.svh"
module noise_filter
(
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic pin,
    input wire logic tick,
    input wire logic need_three,
    output logic level_ff
);
    logic last_ff;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic accept;

    // Count repeats of the same sample level, saturating
    always_comb
    begin
        if (pin == last_ff)
            nxt_cnt = (cnt_ff == `EXTINT_CNT_MAX) ? cnt_ff : cnt_ff + 2'h1;
        else
            nxt_cnt = 2'h0;
        accept = nxt_cnt >= (need_three ? `EXTINT_NEED_THREE : `EXTINT_NEED_TWO);
    end

    // Frozen while run is low, as if its clock had stopped
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            last_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end
        else if (run && tick)
        begin
            last_ff <= pin;
            cnt_ff <= nxt_cnt;
        end
    end

    // Level passes only after enough equal samples
    always_ff @(posedge clk)
    begin
        if (reset)
            level_ff <= 1'b0;
        else if (run && tick && accept)
            level_ff <= pin;
    end

    property p_accept_on_tick;
        @(posedge clk) disable iff (reset)
        $changed(level_ff) |-> $past(run && tick);
    endproperty
    a_accept_on_tick: assert property (p_accept_on_tick)
        else $error("filter level changed without a sample");

    property p_three_samples;
        @(posedge clk) disable iff (reset)
        $changed(level_ff) && $past(need_three) |-> $past(cnt_ff) != 2'h0;
    endproperty
    a_three_samples: assert property (p_three_samples)
        else $error("level accepted on fewer than three samples");
endmodule

// file: verif/external_interrupt_conditioner_tb_top.sv
// Self-checking bench for the external interrupt conditioner
`timescale 1ns/1ns
`include "extint_regs.svh"
module external_interrupt_conditioner_tb_top;
    import extint_pkg::*;
    logic clk, reset, reg_wr, reg_rd, low_freq_clock, master_irq_enable;
    logic [`EXTINT_ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    op_mode_t op_mode;
    logic [5:0] src_en, pins, irq_request;
    int failures, compares, iv;
    int cnt[6], base[6];
    int tc_lo[4] = '{1, 1, 2, 16};
    int tc_hi[4] = '{1, 1, 2, 24};
    logic [7:0] tc_rd[4] = '{8'h10, 8'h04, 8'h08, 8'h1c};

    external_interrupt_conditioner dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .op_mode(op_mode), .low_freq_clock(low_freq_clock), .ext_source_zero(pins[0]),
        .ext_pin1(pins[1]), .ext_pin2(pins[2]), .ext_pin3(pins[3]), .ext_pin4(pins[4]),
        .ext_source_five(pins[5]), .master_irq_enable(master_irq_enable),
        .source0_enable_flag(src_en[0]), .source1_enable_flag(src_en[1]),
        .source2_enable_flag(src_en[2]), .source3_enable_flag(src_en[3]),
        .source4_enable_flag(src_en[4]), .source5_enable_flag(src_en[5]),
        .irq_request(irq_request));
    pin_source_model src (.clk(clk), .pins(pins));

    // 250 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Slow clock enable every second cycle, so one sample per 8 cycles
    always @(posedge clk)
        low_freq_clock <= ~low_freq_clock;

    // Count request cycles; an unknown never counts as a request
    always @(posedge clk)
        for (int i = 0; i < 6; i++)
            cnt[i] += (irq_request[i] === 1'b1) ? 1 : 0;

    task automatic final_report();
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic fail(input string msg);
        failures++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic cmp_reg(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        compares++;
        if (reg_rdata !== exp)
            fail("register read value");
    endtask

    // Requests seen on one source since its last check
    task automatic cmp_cnt(input int i, input int lo, input int hi);
        compares++;
        if (cnt[i] - base[i] < lo || cnt[i] - base[i] > hi)
            fail("request count");
        base[i] = cnt[i];
    endtask

    // Masked rewrite, since a control change may raise a spurious request
    task automatic cfg(input int s, input logic [7:0] v);
        @(posedge clk);
        master_irq_enable <= 1'b0;
        wr(12'(`EXTINT_ADDR_CTL1 + s - 1), v);
        repeat (8) @(posedge clk);
        master_irq_enable <= 1'b1;
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        fail("run did not finish");
        final_report();
    end

    initial
    begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        op_mode = high_speed_run;
        low_freq_clock = 1'b0;
        master_irq_enable = 1'b0;
        src_en = 6'h00;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        cmp_reg(`EXTINT_ADDR_GATE, 8'h00);
        cmp_reg(`EXTINT_ADDR_CTL4, 8'h00);
        @(posedge clk);
        master_irq_enable <= 1'b1;
        src_en <= 6'h3f;
        src.pulse(0, 1'b0, 10);
        cmp_cnt(0, 0, 0);
        @(posedge clk);
        master_irq_enable <= 1'b0;
        wr(`EXTINT_ADDR_GATE, 8'h01);
        wr(`EXTINT_ADDR_CTL4, 8'hff);
        cmp_reg(`EXTINT_ADDR_CTL4, 8'h0f);
        cmp_reg(12'hfdc, 8'h00);
        cmp_reg(`EXTINT_ADDR_GATE, 8'h01);
        @(posedge clk);
        master_irq_enable <= 1'b1;
        // Fixed sources: short glitch dropped, falling edge only
        for (int k = 0; k < 2; k++)
        begin
            src.pulse(k * 5, 1'b0, 1);
            cmp_cnt(k * 5, 0, 0);
            src.pulse(k * 5, 1'b0, 3);
            cmp_cnt(k * 5, 1, 1);
        end
        // Master off, then source flag off
        @(posedge clk);
        master_irq_enable <= 1'b0;
        src.pulse(0, 1'b0, 5);
        cmp_cnt(0, 0, 0);
        master_irq_enable <= 1'b1;
        src_en[5] <= 1'b0;
        src.pulse(5, 1'b0, 5);
        cmp_cnt(5, 0, 0);
        src_en[5] <= 1'b1;
        // Every interval code on every configurable source, rising edge
        for (int s = 1; s < 5; s++)
            for (int nc = 0; nc < 4; nc++)
            begin
                iv = (nc == 0) ? 1 : (4 << (nc - 1));
                cfg(s, 8'(nc));
                src.pulse(s, 1'b1, 2 * iv - 1);
                cmp_cnt(s, 0, 0);
                src.pulse(s, 1'b1, 3 * iv + 2);
                cmp_cnt(s, 1, 1);
            end
        cmp_reg(`EXTINT_ADDR_CTL1, 8'h13);
        // High-level code exists only on source four
        cfg(2, 8'h0c);
        src.pulse(2, 1'b1, 20);
        cmp_cnt(2, 0, 0);
        // Trigger codes on source four and the captured level
        for (int c = 0; c < 4; c++)
        begin
            cfg(4, 8'(c * 4));
            src.pulse(4, 1'b1, 20);
            cmp_cnt(4, tc_lo[c], tc_hi[c]);
            cmp_reg(`EXTINT_ADDR_CTL4, tc_rd[c]);
        end
        // Slow modes ignore the slowest interval code
        cfg(4, 8'h03);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            master_irq_enable <= 1'b0;
            op_mode <= (m == 0) ? low_speed_run : low_speed_sleep;
            repeat (24) @(posedge clk);
            master_irq_enable <= 1'b1;
            src.pulse(4, 1'b1, 7);
            cmp_cnt(4, 0, 0);
            src.pulse(4, 1'b1, 20);
            cmp_cnt(4, 1, 1);
            src.pulse(0, 1'b0, 7);
            cmp_cnt(0, 0, 0);
            src.pulse(0, 1'b0, 20);
            cmp_cnt(0, 1, 1);
        end
        @(posedge clk);
        master_irq_enable <= 1'b0;
        op_mode <= high_speed_run;
        repeat (52) @(posedge clk);
        master_irq_enable <= 1'b1;
        src.pulse(4, 1'b1, 52);
        cmp_cnt(4, 1, 1);
        // Gate off, then halted mode: both freeze sampling
        for (int g = 0; g < 2; g++)
        begin
            @(posedge clk);
            master_irq_enable <= 1'b0;
            if (g == 1)
                op_mode <= halted_mode;
            wr(`EXTINT_ADDR_GATE, 8'(g));
            cmp_reg(`EXTINT_ADDR_GATE, 8'(g));
            @(posedge clk);
            master_irq_enable <= 1'b1;
            src.pulse(0, 1'b0, 20);
            cmp_cnt(0, 0, 0);
        end
        // Idle mode samples like run mode
        master_irq_enable <= 1'b0;
        op_mode <= high_speed_idle;
        repeat (52) @(posedge clk);
        master_irq_enable <= 1'b1;
        src.pulse(0, 1'b0, 3);
        cmp_cnt(0, 1, 1);
        final_report();
    end
endmodule

// file: verif/pin_source_model.sv
// Board-side signal sources for the six external interrupt pins
`timescale 1ns/1ns
module pin_source_model
(
    input wire logic clk,
    output logic [5:0] pins
);
    // Fixed falling-edge pins idle high, configurable pins idle low
    initial pins = 6'h21;

    // Drive one pin away from idle for a width, then let it settle
    task automatic pulse(input int idx, input logic lvl, input int width);
        @(posedge clk);
        pins[idx] <= lvl;
        repeat (width) @(posedge clk);
        pins[idx] <= ~lvl;
        // Long enough for the slowest filter to return to idle
        repeat (80) @(posedge clk);
    endtask
endmodule
